// ===== logic/lcb_csr_bank.sv
// lane conditioning register bank of a four-lane redriver
// Function
// - lane two boost: none, 3.5 dB, 6 dB
// - lane two drive fields act only with individual control
// - native mode ignores boost writes, clock unboosted
// - per-lane bank honoured only in alternate mode
// - two reserved bytes read zero, ignore writes
// - gain register holds lane one and two
// - gain register holds clock and lane zero
// - gain fields reset to zero, zero dB
// - lane two low bits reserved, writable, zero
// - input lane order can be swapped
// - configure by serial bus or pin straps
`timescale 1ns/1ps
module lcb_csr_bank (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // serial configuration pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // strap pins
  input wire logic rx_gain_strap_a,
  input wire logic rx_gain_strap_b,
  input wire logic boost_strap_pin,
  input wire logic cfgByStrap,
  // global control bits from the shared control register
  input wire logic laneSwapSel,
  input wire logic laneIndivEn,
  input wire logic alternate_port_mode,
  input wire logic [2:0] globalSwing,
  input wire logic [1:0] globalBoost,
  // settings to the analog lanes
  output logic [2:0] laneTwoSwing,
  output logic [1:0] laneTwoBoost,
  output logic [1:0] clockLaneBoost,
  output lcb_pkg::lcb_gain_t rxGain,
  output lcb_pkg::lcb_order_t laneOrder
);
  typedef enum logic [4:0] {
    HIT_LANE_TWO = 5'h01,
    HIT_RSVD_A = 5'h02,
    HIT_RSVD_B = 5'h04,
    HIT_GAIN_ONE_TWO = 5'h08,
    HIT_GAIN_CLK_ZERO = 5'h10,
    HIT_NONE = 5'h00
  } lcb_hit_t;

  lcb_pkg::lcb_wr_t wrReq;
  logic [7:0] rdAddr, rdData;
  logic [7:0] lane_two_drive_control_reg;
  logic [7:0] rx_gain_lanes_one_two_reg;
  logic [7:0] rx_gain_clock_lane_zero_reg;
  logic [lcb_pkg::STRAP_PINS-1:0] strapRaw, strapS1, strapS2;
  logic [3:0] strapGain;
  logic perLaneOn;
  lcb_hit_t wrHit, rdHit;

  function automatic lcb_hit_t decodeAddr(input logic [7:0] a);
    case (a)
      lcb_pkg::ADDR_LANE_TWO_DRIVE_CONTROL: decodeAddr = HIT_LANE_TWO;
      lcb_pkg::ADDR_LANE_STUB_RESERVED_A: decodeAddr = HIT_RSVD_A;
      lcb_pkg::ADDR_LANE_STUB_RESERVED_B: decodeAddr = HIT_RSVD_B;
      lcb_pkg::ADDR_RX_GAIN_LANES_ONE_TWO: decodeAddr = HIT_GAIN_ONE_TWO;
      lcb_pkg::ADDR_RX_GAIN_CLOCK_LANE_ZERO: decodeAddr = HIT_GAIN_CLK_ZERO;
      default: decodeAddr = HIT_NONE;
    endcase
  endfunction

  // maps the two equalizer straps onto a gain code
  function automatic logic [3:0] strapToGain(input logic [1:0] s);
    case (s)
      2'h0: strapToGain = lcb_pkg::EQ_STRAP_0;
      2'h1: strapToGain = lcb_pkg::EQ_STRAP_1;
      2'h2: strapToGain = lcb_pkg::EQ_STRAP_2;
      default: strapToGain = lcb_pkg::EQ_STRAP_3;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  lcb_i2c_slave u_slave (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe),
    .wrReq(wrReq),
    .rdAddr(rdAddr),
    .rdData(rdData)
  );

  assign wrHit = decodeAddr(wrReq.addr);
  assign rdHit = decodeAddr(rdAddr);

  ////////////////////////////////////////////////////////////////////////
  // strap pins are asynchronous levels
  assign strapRaw = {boost_strap_pin, rx_gain_strap_b, rx_gain_strap_a};

  genvar gi;
  generate
    for (gi = 0; gi < lcb_pkg::STRAP_PINS; gi++) begin : g_strap
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          strapS1[gi] <= 1'b0;
          strapS2[gi] <= 1'b0;
        end else if (ce) begin
          strapS1[gi] <= strapRaw[gi];
          strapS2[gi] <= strapS1[gi];
        end
      end
    end
  endgenerate

  assign strapGain = strapToGain(strapS2[1:0]);

  ////////////////////////////////////////////////////////////////////////
  // lane two drive control
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      lane_two_drive_control_reg <= lcb_pkg::RST_LANE_TWO_DRIVE_CONTROL;
    end else if (ce && wrReq.stb && wrHit == HIT_LANE_TWO) begin
      lane_two_drive_control_reg[lcb_pkg::SWING_MSB:lcb_pkg::SWING_LSB] <=
        wrReq.data[lcb_pkg::SWING_MSB:lcb_pkg::SWING_LSB];
      lane_two_drive_control_reg[lcb_pkg::RSVD_MSB:lcb_pkg::RSVD_LSB] <=
        wrReq.data[lcb_pkg::RSVD_MSB:lcb_pkg::RSVD_LSB];
      if (alternate_port_mode) begin
        lane_two_drive_control_reg[lcb_pkg::BOOST_MSB:lcb_pkg::BOOST_LSB] <=
          wrReq.data[lcb_pkg::BOOST_MSB:lcb_pkg::BOOST_LSB];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_gain_lanes_one_two_reg <= {lcb_pkg::RST_RX_GAIN, lcb_pkg::RST_RX_GAIN};
    end else if (ce && wrReq.stb && wrHit == HIT_GAIN_ONE_TWO) begin
      rx_gain_lanes_one_two_reg <= wrReq.data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rx_gain_clock_lane_zero_reg <= {lcb_pkg::RST_RX_GAIN, lcb_pkg::RST_RX_GAIN};
    end else if (ce && wrReq.stb && wrHit == HIT_GAIN_CLK_ZERO) begin
      rx_gain_clock_lane_zero_reg <= wrReq.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux; the slave registers the byte it shifts out
  always_comb begin
    unique case (rdHit)
      HIT_LANE_TWO: rdData = lane_two_drive_control_reg;
      HIT_RSVD_A, HIT_RSVD_B: rdData = lcb_pkg::RST_RESERVED;
      HIT_GAIN_ONE_TWO: rdData = rx_gain_lanes_one_two_reg;
      HIT_GAIN_CLK_ZERO: rdData = rx_gain_clock_lane_zero_reg;
      default: rdData = lcb_pkg::READ_UNMAPPED;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // individual control gate
  assign perLaneOn = laneIndivEn && alternate_port_mode;

  // lane two swing and boost
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      laneTwoSwing <= 3'h0;
      laneTwoBoost <= lcb_pkg::BOOST_NONE;
    end else if (ce) begin
      if (cfgByStrap) begin
        laneTwoSwing <= globalSwing;
        laneTwoBoost <= strapS2[2] ? lcb_pkg::BOOST_6DB : lcb_pkg::BOOST_NONE;
      end else if (perLaneOn) begin
        laneTwoSwing <= lane_two_drive_control_reg[lcb_pkg::SWING_MSB:lcb_pkg::SWING_LSB];
        if (lane_two_drive_control_reg[lcb_pkg::BOOST_MSB:lcb_pkg::BOOST_LSB]
            == lcb_pkg::BOOST_RSVD) begin
          laneTwoBoost <= lcb_pkg::BOOST_NONE;
        end else begin
          laneTwoBoost <= lane_two_drive_control_reg[lcb_pkg::BOOST_MSB:lcb_pkg::BOOST_LSB];
        end
      end else begin
        laneTwoSwing <= globalSwing;
        laneTwoBoost <= globalBoost;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      clockLaneBoost <= lcb_pkg::BOOST_NONE;
    end else if (ce) begin
      clockLaneBoost <= (alternate_port_mode && !cfgByStrap) ? globalBoost : lcb_pkg::BOOST_NONE;
    end
  end

  // equalizer gains; strap code stands in when the bank is not honoured
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rxGain <= '0;
    end else if (ce) begin
      if (alternate_port_mode && !cfgByStrap) begin
        rxGain.clk <= rx_gain_clock_lane_zero_reg[lcb_pkg::GAIN_HI_MSB:lcb_pkg::GAIN_HI_LSB];
        rxGain.d0 <= rx_gain_clock_lane_zero_reg[lcb_pkg::GAIN_LO_MSB:lcb_pkg::GAIN_LO_LSB];
        rxGain.d1 <= rx_gain_lanes_one_two_reg[lcb_pkg::GAIN_HI_MSB:lcb_pkg::GAIN_HI_LSB];
        rxGain.d2 <= rx_gain_lanes_one_two_reg[lcb_pkg::GAIN_LO_MSB:lcb_pkg::GAIN_LO_LSB];
      end else begin
        rxGain <= {strapGain, strapGain, strapGain, strapGain};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      laneOrder <= {2'h3, 2'h0, 2'h1, 2'h2};
    end else if (ce) begin
      laneOrder <= laneSwapSel ? {2'h0, 2'h3, 2'h2, 2'h1} : {2'h3, 2'h0, 2'h1, 2'h2};
    end
  end
endmodule

// ===== logic/lcb_pkg.sv
// constants and types shared by the lane conditioning register bank
package lcb_pkg;
  // register offsets on the serial configuration bus
  localparam logic [7:0] ADDR_LANE_TWO_DRIVE_CONTROL = 8'h34;
  localparam logic [7:0] ADDR_LANE_STUB_RESERVED_A = 8'h35;
  localparam logic [7:0] ADDR_LANE_STUB_RESERVED_B = 8'h4D;
  localparam logic [7:0] ADDR_RX_GAIN_LANES_ONE_TWO = 8'h4E;
  localparam logic [7:0] ADDR_RX_GAIN_CLOCK_LANE_ZERO = 8'h4F;
  // reset values
  localparam logic [7:0] RST_LANE_TWO_DRIVE_CONTROL = 8'h00;
  localparam logic [7:0] RST_RESERVED = 8'h00;
  localparam logic [3:0] RST_RX_GAIN = 4'h0;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  // lane two drive control fields
  localparam int SWING_MSB = 7;
  localparam int SWING_LSB = 5;
  localparam int BOOST_MSB = 4;
  localparam int BOOST_LSB = 3;
  localparam int RSVD_MSB = 2;
  localparam int RSVD_LSB = 0;
  // gain register fields
  localparam int GAIN_HI_MSB = 7;
  localparam int GAIN_HI_LSB = 4;
  localparam int GAIN_LO_MSB = 3;
  localparam int GAIN_LO_LSB = 0;
  // boost codes
  localparam logic [1:0] BOOST_NONE = 2'h0;
  localparam logic [1:0] BOOST_3P5DB = 2'h1;
  localparam logic [1:0] BOOST_6DB = 2'h2;
  localparam logic [1:0] BOOST_RSVD = 2'h3;
  // gain codes chosen by the two equalizer strap pins
  localparam logic [3:0] EQ_STRAP_0 = 4'h0;
  localparam logic [3:0] EQ_STRAP_1 = 4'h4;
  localparam logic [3:0] EQ_STRAP_2 = 4'h8;
  localparam logic [3:0] EQ_STRAP_3 = 4'hC;
  // serial bus device address, value is arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h2C;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int STRAP_PINS = 3;

  // one registered write from the serial slave
  typedef struct packed {
    logic stb;
    logic [7:0] addr;
    logic [7:0] data;
  } lcb_wr_t;

  // equalizer gains handed to the analog lanes
  typedef struct packed {
    logic [3:0] clk;
    logic [3:0] d0;
    logic [3:0] d1;
    logic [3:0] d2;
  } lcb_gain_t;

  // physical input pin feeding each logical lane
  typedef struct packed {
    logic [1:0] clk;
    logic [1:0] d0;
    logic [1:0] d1;
    logic [1:0] d2;
  } lcb_order_t;
endpackage

// ===== logic/lcb_i2c_slave.sv
// two-wire serial slave with pointer byte and auto-increment
`timescale 1ns/1ps
module lcb_i2c_slave (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // serial pins, sda open drain
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // register side
  output lcb_pkg::lcb_wr_t wrReq,
  output logic [7:0] rdAddr,
  input wire logic [7:0] rdData
);
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_ADDR = 7'h02,
    ST_ACKA = 7'h04,
    ST_RX = 7'h08,
    ST_ACKW = 7'h10,
    ST_TX = 7'h20,
    ST_RACK = 7'h40
  } lcb_st_t;

  lcb_st_t state;
  logic sclS1, sclS2, sclD, sdaS1, sdaS2, sdaD;
  logic [3:0] bitCnt;
  logic [7:0] shiftReg;
  logic [7:0] ptrReg;
  logic isRead, ptrLoaded, masterNack;
  logic startSeen, stopSeen, sclRise, sclFall;

  assign sdaOut = 1'b0;
  assign rdAddr = ptrReg;
  assign startSeen = sclS2 && sdaD && !sdaS2;
  assign stopSeen = sclS2 && !sdaD && sdaS2;
  assign sclRise = sclS2 && !sclD;
  assign sclFall = !sclS2 && sclD;

  ////////////////////////////////////////////////////////////////////////
  // pins cross in through two flops before any decoding
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      {sclS1, sclS2, sclD} <= 3'h7;
      {sdaS1, sdaS2, sdaD} <= 3'h7;
    end else if (ce) begin
      {sclS1, sclS2, sclD} <= {sclIn, sclS1, sclS2};
      {sdaS1, sdaS2, sdaD} <= {sdaIn, sdaS1, sdaS2};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      bitCnt <= 4'h0;
      shiftReg <= 8'h00;
      ptrReg <= 8'h00;
      isRead <= 1'b0;
      ptrLoaded <= 1'b0;
      masterNack <= 1'b0;
      sdaOe <= 1'b0;
      wrReq <= '0;
    end else if (ce) begin
      wrReq.stb <= 1'b0;
      if (startSeen) begin
        // repeated start keeps the pointer for a following read
        state <= ST_ADDR;
        bitCnt <= 4'h0;
        sdaOe <= 1'b0;
      end else if (stopSeen) begin
        state <= ST_IDLE;
        sdaOe <= 1'b0;
      end else begin
        unique case (state)
          ST_IDLE: begin
          end
          ST_ADDR, ST_RX: begin
            if (sclRise) begin
              shiftReg <= {shiftReg[6:0], sdaS2};
              bitCnt <= bitCnt + 4'h1;
            end else if (sclFall && bitCnt == lcb_pkg::BITS_PER_BYTE) begin
              bitCnt <= 4'h0;
              if (state == ST_ADDR) begin
                if (shiftReg[7:1] == lcb_pkg::DEV_ADDR) begin
                  sdaOe <= 1'b1;
                  isRead <= shiftReg[0];
                  ptrLoaded <= 1'b0;
                  state <= ST_ACKA;
                end else begin
                  state <= ST_IDLE;
                end
              end else begin
                sdaOe <= 1'b1;
                state <= ST_ACKW;
                ptrLoaded <= 1'b1;
                if (!ptrLoaded) begin
                  ptrReg <= shiftReg;
                end else begin
                  wrReq.stb <= 1'b1;
                  wrReq.addr <= ptrReg;
                  wrReq.data <= shiftReg;
                  ptrReg <= ptrReg + 8'h01;
                end
              end
            end
          end
          ST_ACKA: begin
            if (sclFall) begin
              if (isRead) begin
                shiftReg <= rdData;
                sdaOe <= !rdData[7];
                state <= ST_TX;
              end else begin
                sdaOe <= 1'b0;
                state <= ST_RX;
              end
            end
          end
          ST_ACKW: begin
            if (sclFall) begin
              sdaOe <= 1'b0;
              state <= ST_RX;
            end
          end
          ST_TX: begin
            if (sclFall) begin
              if (bitCnt == lcb_pkg::BITS_PER_BYTE - 4'h1) begin
                sdaOe <= 1'b0;
                bitCnt <= 4'h0;
                ptrReg <= ptrReg + 8'h01;
                state <= ST_RACK;
              end else begin
                shiftReg <= {shiftReg[6:0], 1'b0};
                sdaOe <= !shiftReg[6];
                bitCnt <= bitCnt + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (sclRise) begin
              masterNack <= sdaS2;
            end else if (sclFall) begin
              if (!masterNack) begin
                // pointer already moved, so this is the next byte
                shiftReg <= rdData;
                sdaOe <= !rdData[7];
                state <= ST_TX;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
            sdaOe <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

// ===== verif/lcb_csr_bank_properties.sv
// port-level checks of the lane conditioning register bank
`timescale 1ns/1ps
module lcb_csr_bank_properties (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // serial pins
  input wire logic sclIn,
  input wire logic sdaOe,
  // global controls
  input wire logic cfgByStrap,
  input wire logic laneSwapSel,
  input wire logic laneIndivEn,
  input wire logic alternate_port_mode,
  input wire logic [2:0] globalSwing,
  input wire logic [1:0] globalBoost,
  // lane settings
  input wire logic [2:0] laneTwoSwing,
  input wire logic [1:0] laneTwoBoost,
  input wire logic [1:0] clockLaneBoost,
  input wire lcb_pkg::lcb_gain_t rxGain,
  input wire lcb_pkg::lcb_order_t laneOrder
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // sda may only move while scl is low, else it forges a start or stop
  AST_OE_SCL_LOW: assert property (
    $changed(sdaOe) |-> !sclIn) else $error("sda driven while scl high");
  AST_RESET_STATE: assert property (
    $rose(rst_b) |-> rxGain == 16'h0000 && laneOrder == 8'hC6 && laneTwoBoost == 2'h0)
    else $error("outputs wrong after reset");
  AST_BOOST_RSVD: assert property (
    ce && laneIndivEn && alternate_port_mode && !cfgByStrap |=>
    laneTwoBoost != lcb_pkg::BOOST_RSVD) else $error("reserved boost code driven");
  AST_GLOBAL_SWING: assert property (
    ce && !(laneIndivEn && alternate_port_mode) |=> laneTwoSwing == $past(globalSwing))
    else $error("swing not global");
  AST_GLOBAL_BOOST: assert property (
    ce && !cfgByStrap && !(laneIndivEn && alternate_port_mode) |=>
    laneTwoBoost == $past(globalBoost)) else $error("boost not global");
  AST_CLOCK_BOOST: assert property (
    ce |=> clockLaneBoost == (($past(alternate_port_mode) && !$past(cfgByStrap)) ?
    $past(globalBoost) : 2'h0)) else $error("clock lane boost wrong");
  AST_GAIN_NATIVE: assert property (
    ce && !alternate_port_mode |=> rxGain.clk == rxGain.d2 && rxGain.d0 == rxGain.d1 &&
    rxGain.d1 == rxGain.d2 && rxGain.d2[1:0] == 2'h0) else $error("gain not strap code");
  AST_LANE_ORDER: assert property (
    ce |=> laneOrder == ($past(laneSwapSel) ? 8'h39 : 8'hC6))
    else $error("lane order wrong");
  AST_STRAP_BOOST: assert property (
    ce && cfgByStrap |=> laneTwoBoost inside {2'h0, 2'h2})
    else $error("strap boost out of range");
  AST_CE_FREEZE: assert property (
    !ce |=> $stable(laneOrder) && $stable(rxGain) && $stable(laneTwoBoost))
    else $error("outputs moved with clock enable low");
endmodule

bind lcb_csr_bank lcb_csr_bank_properties i_props (
  .clk(clk), .rst_b(rst_b), .ce(ce), .sclIn(sclIn), .sdaOe(sdaOe),
  .cfgByStrap(cfgByStrap), .laneSwapSel(laneSwapSel), .laneIndivEn(laneIndivEn),
  .alternate_port_mode(alternate_port_mode), .globalSwing(globalSwing),
  .globalBoost(globalBoost), .laneTwoSwing(laneTwoSwing), .laneTwoBoost(laneTwoBoost),
  .clockLaneBoost(clockLaneBoost), .rxGain(rxGain), .laneOrder(laneOrder)
);

// ===== verif/lcb_host_model.sv
// two-wire bus host driving the register bank serial pins
`timescale 1ns/1ps
module lcb_host_model (
  // clock
  input wire logic clk,
  // serial pins
  input wire logic sdaOe,
  output logic sclIn,
  output logic sdaIn
);
  // enable pin untouched; supplies settled from time zero
  logic hostLow = 1'b0;
  logic sclReg = 1'b1;
  // pull-up: sda high unless some party pulls it low
  assign sdaIn = !(hostLow || sdaOe);
  assign sclIn = sclReg;

  // 8 clocks a phase, twice the minimum the slave resolves
  task automatic step(input logic s, input logic l);
    sclReg <= s;
    hostLow <= l;
    repeat (8) @(posedge clk);
  endtask

  task automatic start();
    step(sclReg, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
  endtask

  task automatic stop();
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b1, 1'b0);
  endtask

  // data only changes with scl low
  task automatic putByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      step(1'b0, !b[i]);
      step(1'b1, !b[i]);
      step(1'b0, !b[i]);
    end
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    ack = !sdaIn;
    step(1'b0, 1'b0);
  endtask

  task automatic getByte(input logic last, output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      b[i] = sdaIn;
      step(1'b0, 1'b0);
    end
    step(1'b0, !last);
    step(1'b1, !last);
    step(1'b0, !last);
  endtask

  task automatic wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] d,
      output logic ack);
    logic k1, k2, k3;
    start();
    putByte({dev, 1'b0}, k1);
    putByte(a, k2);
    putByte(d, k3);
    stop();
    ack = k1 && k2 && k3;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic k;
    start();
    putByte({lcb_pkg::DEV_ADDR, 1'b0}, k);
    putByte(a, k);
    start();
    putByte({lcb_pkg::DEV_ADDR, 1'b1}, k);
    getByte(1'b1, d);
    stop();
  endtask

  // two data bytes in one frame, so the pointer has to step on its own
  task automatic wrPair(input logic [7:0] a, input logic [15:0] d);
    logic k;
    start();
    putByte({lcb_pkg::DEV_ADDR, 1'b0}, k);
    putByte(a, k);
    putByte(d[15:8], k);
    putByte(d[7:0], k);
    stop();
  endtask

  // first byte acked by the host, second refused to end the frame
  task automatic rdPair(input logic [7:0] a, output logic [15:0] d);
    logic k;
    start();
    putByte({lcb_pkg::DEV_ADDR, 1'b0}, k);
    putByte(a, k);
    start();
    putByte({lcb_pkg::DEV_ADDR, 1'b1}, k);
    getByte(1'b0, d[15:8]);
    getByte(1'b1, d[7:0]);
    stop();
  endtask
endmodule

// ===== verif/lane_conditioning_csr_bank_bench.sv
// self-checking bench for the lane conditioning register bank
`timescale 1ns/1ps
module lane_conditioning_csr_bank_bench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic sclIn, sdaIn, sdaOe, sdaOut;
  logic strapA = 1'b0, strapB = 1'b0, strapBoost = 1'b0, cfgByStrap = 1'b0;
  logic laneSwapSel = 1'b0, laneIndivEn = 1'b0, altMode = 1'b0;
  logic [2:0] globalSwing = 3'h0;
  logic [1:0] globalBoost = 2'h0;
  logic [2:0] laneTwoSwing;
  logic [1:0] laneTwoBoost, clockLaneBoost;
  lcb_pkg::lcb_gain_t rxGain;
  lcb_pkg::lcb_order_t laneOrder;
  logic [7:0] m34 = 8'h00, m4e = 8'h00, m4f = 8'h00;
  logic [7:0] addrs[$] = '{8'h34, 8'h35, 8'h4D, 8'h4E, 8'h4F, 8'h50};
  logic [7:0] q;
  logic [15:0] w;
  logic ack;
  int num_errors = 0;
  int samples_checked = 0;

  lcb_csr_bank i_dut (
    .clk(clk), .rst_b(rst_b), .ce(ce), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .rx_gain_strap_a(strapA), .rx_gain_strap_b(strapB),
    .boost_strap_pin(strapBoost), .cfgByStrap(cfgByStrap), .laneSwapSel(laneSwapSel),
    .laneIndivEn(laneIndivEn), .alternate_port_mode(altMode), .globalSwing(globalSwing),
    .globalBoost(globalBoost), .laneTwoSwing(laneTwoSwing), .laneTwoBoost(laneTwoBoost),
    .clockLaneBoost(clockLaneBoost), .rxGain(rxGain), .laneOrder(laneOrder)
  );
  lcb_host_model i_host (.clk(clk), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn));

  initial begin
    forever #12.5 clk = !clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] expRd(input logic [7:0] a);
    case (a)
      lcb_pkg::ADDR_LANE_TWO_DRIVE_CONTROL: return m34;
      lcb_pkg::ADDR_RX_GAIN_LANES_ONE_TWO: return m4e;
      lcb_pkg::ADDR_RX_GAIN_CLOCK_LANE_ZERO: return m4f;
      default: return 8'h00;
    endcase
  endfunction

  task automatic chkOut();
    logic per, alt;
    logic [1:0] b;
    logic [3:0] s;
    per = laneIndivEn && altMode && !cfgByStrap;
    alt = altMode && !cfgByStrap;
    // reserved boost code is stored but never driven
    b = (m34[4:3] == 2'h3) ? 2'h0 : m34[4:3];
    s = {strapB, strapA, 2'h0};
    check(16'(laneTwoSwing), 16'(per ? m34[7:5] : globalSwing));
    check(16'(laneTwoBoost), 16'(cfgByStrap ? {strapBoost, 1'b0} : per ? b : globalBoost));
    check(16'(clockLaneBoost), 16'(alt ? globalBoost : 2'h0));
    check(rxGain, alt ? {m4f, m4e} : {4{s}});
    check(16'(laneOrder), 16'(laneSwapSel ? 8'h39 : 8'hC6));
    check(16'(sdaOut), 16'h0000);
  endtask

  task automatic wrChk(input logic [7:0] a, input logic [7:0] d);
    logic k;
    logic [7:0] r;
    i_host.wr(lcb_pkg::DEV_ADDR, a, d, k);
    check(16'(k), 16'h0001);
    // native mode keeps the old boost bits
    if (a == lcb_pkg::ADDR_LANE_TWO_DRIVE_CONTROL) m34 = altMode ? d : {d[7:5], m34[4:3], d[2:0]};
    if (a == lcb_pkg::ADDR_RX_GAIN_LANES_ONE_TWO) m4e = d;
    if (a == lcb_pkg::ADDR_RX_GAIN_CLOCK_LANE_ZERO) m4f = d;
    repeat (8) @(posedge clk);
    chkOut();
    i_host.rd(a, r);
    check(16'(r), 16'(expRd(a)));
  endtask

  task automatic doReset();
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    m34 = 8'h00;
    m4e = 8'h00;
    m4f = 8'h00;
    repeat (3) @(posedge clk);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hB345));
    @(posedge clk);
    doReset();
    altMode <= 1'b1;
    laneIndivEn <= 1'b1;
    repeat (8) @(posedge clk);
    chkOut();
    foreach (addrs[i]) begin
      i_host.rd(addrs[i], q);
      check(16'(q), 16'(expRd(addrs[i])));
    end
    for (int k = 0; k < 4; k++) begin
      wrChk(8'h34, {3'($urandom()), 2'(k), 3'($urandom())});
    end
    altMode <= 1'b0;
    wrChk(8'h34, 8'h0F);
    repeat (12) begin
      {strapA, strapB, strapBoost, laneSwapSel, laneIndivEn, globalSwing} <= 8'($urandom());
      globalBoost <= 2'($urandom_range(2));
      altMode <= ($urandom_range(3) != 0);
      cfgByStrap <= ($urandom_range(3) == 0);
      @(posedge clk);
      wrChk(addrs[$urandom_range(5)], 8'($urandom()));
    end
    // pointer steps from one gain register to the next within a frame
    w = 16'($urandom());
    i_host.wrPair(lcb_pkg::ADDR_RX_GAIN_LANES_ONE_TWO, w);
    {m4e, m4f} = w;
    i_host.rdPair(lcb_pkg::ADDR_RX_GAIN_LANES_ONE_TWO, w);
    check(w, {m4e, m4f});
    chkOut();
    // a foreign device address must be ignored whole
    i_host.wr(lcb_pkg::DEV_ADDR ^ 7'h01, 8'h4E, 8'h5A, ack);
    check(16'(ack), 16'h0000);
    // clock enable low: the order keeps its old mapping
    ce <= 1'b0;
    laneSwapSel <= !laneSwapSel;
    repeat (8) @(posedge clk);
    check(16'(laneOrder), 16'(laneSwapSel ? 8'hC6 : 8'h39));
    ce <= 1'b1;
    repeat (8) @(posedge clk);
    chkOut();
    cfgByStrap <= 1'b0;
    altMode <= 1'b1;
    doReset();
    repeat (8) @(posedge clk);
    chkOut();
    i_host.rd(8'h4F, q);
    check(16'(q), 16'h0000);
    print_verdict();
  end

  initial begin
    repeat (80000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
endmodule
